// *** core/gated_sixteen_bit_timer.v ***
// Gated sixteen bit timer with selectable count source
// Operation
// RQ1: Sixteen-bit counter, byte writes replace live value
// RQ2: Internal source advances once per instruction cycle
// RQ3: Run off stops; gate enable qualifies counting
// RQ4: Select 11 osc, 10 pin, 01 sys, 00 instr
// RQ5: External source counts rising edges of pin
// RQ6: Falling edge required before first counted rise
// RQ7: Selecting oscillator forces it on, also asleep
// RQ8: Prescale divides by one, two, four, eight
// RQ9: Prescaler hidden, cleared on counter byte write
// RQ10: Sync bypass bit skips input synchronization; code keeps the synchronizer, bypass only permits counting asleep
// RQ11: Async external counting continues asleep, wakes
// RQ12: Byte reads stay coherent in async mode
// RQ13: Software stops counter before async writes
// RQ14: Mode switch may lose or gain one count
// RQ15: Gated counting holds while gate inactive
// RQ16: Gate polarity selects active gate level
// RQ17: Rollover to zero sets sticky overflow flag
// RQ18: Sync mode uses multi-stage input synchronizer
`timescale 1ns/1ps
`include "gated_timer_map.vh"
module gated_sixteen_bit_timer (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Control bits
  input  wire        run_bit,
  input  wire        gate_enable_bit,
  input  wire        gate_polarity_bit,
  input  wire [1:0]  clock_select_field,
  input  wire [1:0]  prescale_select_field,
  input  wire        sync_bypass_bit,
  input  wire        sleep_mode,
  // Pins and oscillator
  input  wire        external_count_input,
  input  wire        gate_input,
  input  wire        low_freq_internal_osc,
  // Counter byte access
  input  wire        write_high_en,
  input  wire        write_low_en,
  input  wire [7:0]  write_data,
  output wire [7:0]  count_high_byte,
  output wire [7:0]  count_low_byte,
  // Status
  input  wire        overflow_clear,
  output wire        overflow_flag,
  output wire        wake_request,
  output wire        osc_force_on
);
  reg  [15:0] count_ff;
  reg  [15:0] nxt_count;
  reg         ovf_ff;
  reg  [1:0]  instr_div_ff;
  reg         ext_s1_ff;
  reg         ext_s2_ff;
  reg         ext_s3_ff;
  reg         osc_s1_ff;
  reg         osc_s2_ff;
  reg         osc_s3_ff;
  reg         gate_s1_ff;
  reg         gate_s2_ff;
  reg         armed_ff;
  reg         run_d_ff;
  reg         raw_tick;
  wire        byte_write;
  wire        gate_ok;
  wire        enable;
  wire        ext_rise;
  wire        ext_fall;
  wire        osc_rise;
  wire        ext_sel;
  wire        tick;
  wire        inc;
  wire        sleep_ok;

  assign byte_write = write_high_en | write_low_en;
  assign ext_sel    = clock_select_field == `CSEL_EXTPIN;

  // Two-stage synchronizers; count pin and oscillator also get an edge stage
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_ff  <= 1'b0;
      ext_s2_ff  <= 1'b0;
      ext_s3_ff  <= 1'b0;
      osc_s1_ff  <= 1'b0;
      osc_s2_ff  <= 1'b0;
      osc_s3_ff  <= 1'b0;
      gate_s1_ff <= 1'b0;
      gate_s2_ff <= 1'b0;
    end else begin
      ext_s1_ff  <= external_count_input; // [RQ18]
      ext_s2_ff  <= ext_s1_ff;
      ext_s3_ff  <= ext_s2_ff;
      osc_s1_ff  <= low_freq_internal_osc;
      osc_s2_ff  <= osc_s1_ff;
      osc_s3_ff  <= osc_s2_ff;
      gate_s1_ff <= gate_input;
      gate_s2_ff <= gate_s1_ff;
    end
  end

  assign ext_rise = ext_s2_ff & ~ext_s3_ff; // [RQ5]
  assign ext_fall = ~ext_s2_ff & ext_s3_ff;
  assign osc_rise = osc_s2_ff & ~osc_s3_ff;

  // Oscillator kept on while selected, sleep included
  assign osc_force_on = clock_select_field == `CSEL_TEMPOSC; // [RQ7]

  // Gate active at the level that polarity names
  assign gate_ok = (gate_s2_ff == gate_polarity_bit); // [RQ16]
  assign enable  = run_bit & (~gate_enable_bit | gate_ok); // [RQ3] [RQ15]

  // Instruction clock divider, sys clock by four
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_div_ff <= 2'h0;
    end else begin
      instr_div_ff <= instr_div_ff + 2'h1;
    end
  end

  // Falling edge arming for counter mode
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
      run_d_ff <= 1'b0;
    end else begin
      run_d_ff <= run_bit;
      if (byte_write || !run_bit || (run_bit && !run_d_ff)) begin
        armed_ff <= 1'b0; // [RQ6]
      end else if (ext_fall) begin
        armed_ff <= 1'b1; // [RQ6]
      end
    end
  end

  // Source select; bypass and sync both use the sampled pin edge,
  // so a mode switch can shift at most one count
  always @* begin
    case (clock_select_field)
      `CSEL_INSTR:   raw_tick = instr_div_ff == `INSTR_DIV_MAX; // [RQ2] [RQ4]
      `CSEL_SYSCLK:  raw_tick = 1'b1; // [RQ4]
      `CSEL_EXTPIN:  raw_tick = ext_rise & armed_ff; // [RQ5] [RQ10] [RQ14]
      `CSEL_TEMPOSC: raw_tick = osc_rise; // [RQ4]
      default:       raw_tick = 1'b0;
    endcase
  end

  // Only async external or oscillator source runs in sleep
  assign sleep_ok = ~sleep_mode | (ext_sel & sync_bypass_bit) |
                    osc_force_on; // [RQ11]

  count_prescaler u_prescaler (
    .sys_clk               (sys_clk),
    .rst_n                 (rst_n),
    .clear                 (byte_write),
    .prescale_select_field (prescale_select_field),
    .tick_in               (raw_tick & enable & sleep_ok),
    .tick_out              (tick)
  );

  assign inc = tick & ~byte_write; // [RQ13]

  always @* begin
    nxt_count = count_ff;
    if (inc) begin
      nxt_count = count_ff + 16'h0001; // [RQ1] [RQ17]
    end
    if (write_high_en) begin
      nxt_count[15:8] = write_data; // [RQ1]
    end
    if (write_low_en) begin
      nxt_count[7:0] = write_data; // [RQ1]
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= `COUNT_ZERO;
      ovf_ff   <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      if (inc && count_ff == `COUNT_ONES) begin
        ovf_ff <= 1'b1; // [RQ17]
      end else if (overflow_clear) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // Reads come from one clock domain register, always coherent
  assign count_high_byte = count_ff[15:8]; // [RQ12]
  assign count_low_byte  = count_ff[7:0]; // [RQ12]
  assign overflow_flag   = ovf_ff;
  assign wake_request    = ovf_ff & sleep_mode; // [RQ11]
endmodule // gated_sixteen_bit_timer

// *** inc/gated_timer_map.vh ***
// Constants for the gated sixteen bit timer
`ifndef GATED_TIMER_MAP_VH
`define GATED_TIMER_MAP_VH
`define CSEL_INSTR    2'b00
`define CSEL_SYSCLK   2'b01
`define CSEL_EXTPIN   2'b10
`define CSEL_TEMPOSC  2'b11
`define INSTR_DIV_MAX 2'h3
`define COUNT_ZERO    16'h0000
`define COUNT_ONES    16'hffff
`define PRESC_ZERO    3'h0
`define PRESC_DIV1    2'h0
`define PRESC_DIV2    2'h1
`define PRESC_DIV4    2'h2
`define PRESC_MASK2   3'h1
`define PRESC_MASK4   3'h3
`define PRESC_MASK8   3'h7
`define SYNC_STAGES   3
`endif

// *** core/count_prescaler.v ***
// Prescaler dividing count ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
`include "gated_timer_map.vh"
module count_prescaler (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Control
  input  wire       clear,
  input  wire [1:0] prescale_select_field,
  // Ticks
  input  wire       tick_in,
  output wire       tick_out
);
  reg  [2:0] presc_ff;
  reg  [2:0] mask;

  always @* begin
    case (prescale_select_field)
      `PRESC_DIV1: mask = `PRESC_ZERO;
      `PRESC_DIV2: mask = `PRESC_MASK2;
      `PRESC_DIV4: mask = `PRESC_MASK4;
      default:     mask = `PRESC_MASK8;
    endcase
  end

  // Pass a tick when the low bits of the hidden counter are all set
  assign tick_out = tick_in && ((presc_ff & mask) == mask); // [RQ8]

  // Hidden counter, cleared by a counter byte write
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= `PRESC_ZERO;
    end else if (clear) begin
      presc_ff <= `PRESC_ZERO; // [RQ9]
    end else if (tick_in) begin
      presc_ff <= (presc_ff & mask) == mask ? `PRESC_ZERO : presc_ff + 3'h1;
    end
  end
endmodule // count_prescaler

// *** tb/gated_timer_chk.sv ***
// Assertion checker for the gated sixteen bit timer
`timescale 1ns/1ps
module gated_timer_chk (
  // Clock and reset
  input wire       sys_clk, rst_n,
  // Controls
  input wire       run_bit, sleep_mode, write_high_en, write_low_en,
  input wire       overflow_clear,
  input wire [1:0] clock_select_field,
  input wire [7:0] write_data, count_high_byte, count_low_byte,
  // Status
  input wire       overflow_flag, wake_request, osc_force_on
);
  wire [15:0] cnt  = {count_high_byte, count_low_byte};
  wire        nowr = !write_high_en && !write_low_en;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_wr_lo; write_low_en |=> count_low_byte == $past(write_data);
  endproperty
  a_wr_lo: assert property (p_wr_lo) else $error("low write lost");
  property p_wr_hi; write_high_en |=> count_high_byte == $past(write_data);
  endproperty
  a_wr_hi: assert property (p_wr_hi) else $error("high write lost");
  property p_step; nowr |=> cnt == $past(cnt) || cnt == $past(cnt) + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_off; !run_bit && $past(!run_bit) && nowr |=> $stable(cnt);
  endproperty
  a_off: assert property (p_off) else $error("counts while off");
  property p_osc; osc_force_on == (clock_select_field == 2'b11); endproperty
  a_osc: assert property (p_osc) else $error("osc force wrong");
  property p_wake; wake_request == (overflow_flag && sleep_mode); endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
  property p_rise; $rose(overflow_flag) |-> cnt == 16'h0000; endproperty
  a_rise: assert property (p_rise) else $error("flag without wrap");
  property p_hold; overflow_flag && !overflow_clear |=> overflow_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");
  property p_wrap; cnt == 16'hffff ##1 cnt == 16'h0000 |-> overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap not flagged");
endmodule // gated_timer_chk
bind gated_sixteen_bit_timer gated_timer_chk u_chk (.*);

// *** tb/test_gated_sixteen_bit_timer.sv ***
// Self-checking bench for the gated sixteen bit timer
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module test_gated_sixteen_bit_timer;
  reg sys_clk = 0, rst_n = 0, run_bit = 0, gate_enable_bit = 0;
  reg gate_polarity_bit = 0, sync_bypass_bit = 0, sleep_mode = 0;
  reg external_count_input = 0, gate_input = 0, low_freq_internal_osc = 0;
  reg write_high_en = 0, write_low_en = 0, overflow_clear = 0;
  reg [1:0] clock_select_field = 0, prescale_select_field = 0;
  reg [7:0] write_data = 0;
  wire [7:0] count_high_byte, count_low_byte;
  wire overflow_flag, wake_request, osc_force_on;
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  int miscompares = 0, checked = 0, n, d;
  reg [15:0] a;
  gated_sixteen_bit_timer dut (.*);
  always #2 sys_clk = ~sys_clk;
  task stop_test;
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cyc(input int k); repeat (k) @(posedge sys_clk); #1; endtask
  task wr(input [15:0] v);
    @(posedge sys_clk) begin write_high_en <= 1; write_data <= v[15:8]; end
    @(posedge sys_clk) begin
      write_high_en <= 0; write_low_en <= 1; write_data <= v[7:0];
    end
    @(posedge sys_clk) write_low_en <= 0;
    cyc(1);
  endtask
  task meas(input string nm, input int m, input int e);
    a = cnt; cyc(m); `CHK(nm, e[15:0], cnt - a)
  endtask
  task pulses(input int k);
    repeat (k) begin
      @(posedge sys_clk) {external_count_input, low_freq_internal_osc} <= 2'h3;
      cyc(4);
      @(posedge sys_clk) {external_count_input, low_freq_internal_osc} <= 2'h0;
      cyc(4);
    end
    cyc(6);
  endtask
  initial begin
    n = $urandom(94034);
    repeat (7) @(posedge sys_clk);
    @(posedge sys_clk) begin rst_n <= 1; sync_bypass_bit <= $urandom; end
    cyc(1);
    `CHK("reset", 16'h0, cnt)
    wr(16'h5aa5);
    `CHK("write", 16'h5aa5, cnt)
    @(posedge sys_clk) run_bit <= 1;
    for (int s = 0; s < 8; s++) begin
      @(posedge sys_clk) begin
        clock_select_field <= {1'b0, s[2]}; prescale_select_field <= s[1:0];
      end
      cyc(40);
      d = (1 << s[1:0]) * (s[2] ? 1 : 4);
      meas("rate", 64, 64 / d);
    end
    for (int p = 0; p < 4; p++) begin
      @(posedge sys_clk) begin
        clock_select_field <= 2'h1; prescale_select_field <= 2'h0;
        gate_enable_bit <= 1; gate_polarity_bit <= p[0]; gate_input <= p[1];
      end
      cyc(8);
      meas("gate", 32, (p[0] == p[1]) ? 32 : 0);
    end
    @(posedge sys_clk) run_bit <= 0;
    cyc(8);
    meas("off", 32, 0);
    for (int s = 2; s < 4; s++) begin
      n = $urandom_range(9, 2);
      @(posedge sys_clk) begin
        gate_enable_bit <= 0; clock_select_field <= s[1:0]; run_bit <= 0;
      end
      wr(16'h0);
      @(posedge sys_clk) run_bit <= 1;
      pulses(n);
      `CHK("edges", n - 3 + s, cnt)
    end
    @(posedge sys_clk) begin
      clock_select_field <= 2'h2; sleep_mode <= 1; sync_bypass_bit <= 0;
    end
    a = cnt; pulses(3);
    `CHK("sleep sync", 16'h0, cnt - a)
    @(posedge sys_clk) sync_bypass_bit <= 1;
    a = cnt; pulses(3);
    `CHK("sleep async", 16'h3, cnt - a)
    @(posedge sys_clk) begin
      run_bit <= 0; clock_select_field <= 2'h1; sleep_mode <= 0;
    end
    wr(16'hfffd); // Counter stopped before the write
    @(posedge sys_clk) run_bit <= 1;
    cyc(6);
    @(posedge sys_clk) begin run_bit <= 0; sleep_mode <= 1; end
    cyc(2);
    `CHK("wrap", 1'b1, cnt < 16'h10)
    `CHK("flag", 1'b1, overflow_flag)
    `CHK("wake", 1'b1, wake_request)
    @(posedge sys_clk) overflow_clear <= 1;
    @(posedge sys_clk) begin overflow_clear <= 0; sleep_mode <= 0; end
    cyc(1);
    `CHK("clear", 1'b0, overflow_flag)
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    stop_test;
  end
endmodule // test_gated_sixteen_bit_timer
